// ---- rtl/scs_defines.svh ----
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// Timing
`define SCS_CLK_MHZ 100
`define SCS_UNDER_MIN_US 5
`define SCS_UNDER_CYC (`SCS_UNDER_MIN_US * `SCS_CLK_MHZ)
`define SCS_DEBOUNCE_MS 40
`define SCS_DEBOUNCE_CYC (`SCS_DEBOUNCE_MS * 1000 * `SCS_CLK_MHZ)
`define SCS_MISMATCH_US 3
`define SCS_MISMATCH_CYC (`SCS_MISMATCH_US * `SCS_CLK_MHZ)

// Register map, byte addresses
`define SCS_ADDR_STATUS 8'h00
`define SCS_ADDR_CFG 8'h04

// Status fields
`define SCS_ST_STATE_LO 0
`define SCS_ST_READY 2
`define SCS_ST_INSERTED 3
`define SCS_ST_LEVEL 4
`define SCS_ST_CH_ON 5
`define SCS_ST_F_UNDER 8
`define SCS_ST_F_TEMP 9
`define SCS_ST_F_REMOVE 10
`define SCS_ST_F_RST 11
`define SCS_ST_F_CLK 12

// Reset values
`define SCS_CFG_RST 16'h012C
`define SCS_SYNC_RST 18'h3FFFF
`define SCS_FAULT_RST 5'h00

`endif

// ---- rtl/scs_pkg.sv ----
package scs_pkg;

   typedef enum logic [1:0] {
      SCS_IDLE,
      SCS_ACTIVE,
      SCS_ALARM
   } scs_state_t;

   typedef enum logic [1:0] {
      SCS_CH_REST,
      SCS_CH_HOST_IN,
      SCS_CH_CARD_IN,
      SCS_CH_SETTLE
   } scs_dir_t;

   // Pin inputs crossing into the system clock domain
   typedef struct packed {
      logic power_request_n;
      logic chan_en_n;
      logic supply_level_sel;
      logic switch_pol_sel;
      logic card_switch_in;
      logic host_reset_in;
      logic host_clock_in;
      logic supply_in_reg;
      logic supply_under;
      logic over_temp;
      logic card_rst_sense;
      logic card_clk_sense;
      logic [2:0] host_line;
      logic [2:0] card_line;
   } scs_pins_t;

   // Sticky fault causes, cleared on return to Idle
   typedef struct packed {
      logic clk_mismatch;
      logic rst_mismatch;
      logic removal;
      logic over_temp;
      logic under;
   } scs_fault_t;

endpackage

// ---- rtl/scs_sequencer.sv ----
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "scs_defines.svh"
// Operation
// - Power request low enters Active and turns on the card supply.
// - Card reset and clock stay disabled until supply-ready goes low.
// - Data channels enabled only when supply ready and channel enable low.
// - Supply level latched at request falling edge, ignored while request low.
// - Disabled channels: card lines forced high, host lines released; Idle and Alarm drive the card lines low instead.
// - Channel enable never touches supply, reset or clock.
// - Polarity select chooses active switch level; inserted flag low means card.
// - Supply underrange lasting 5 us sends the device to Alarm.
// - Idle and Alarm discharge the card supply.
// - Idle drives card data, reset and clock lines low.
// - Channels rest high; first side low is input, other side output.
// - Output side is never passed back to input side while directed.
// - Input release returns both sides high, ready for either direction.
// - Output-side low outlasting input release is not passed back.
// - Direction chosen only from the both-high rest state.
// - Card reset differing from host reset for microseconds means Alarm.
// - Reset mismatch checked only after supply ready.
// - Sustained card clock versus host clock difference means Alarm.
// - Active with supply ready passes host clock and host reset to the card.
// - Alarm held until power request returns high.
// - Overtemperature after supply ready, or card removal, while Active also means Alarm.
// - Inserted after 40 ms continuous presence, released within 50 us.
module scs_sequencer #(
   parameter int DEBOUNCE_CYC = `SCS_DEBOUNCE_CYC,
   parameter int UNDER_CYC = `SCS_UNDER_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic POWER_REQUEST_N,
   input wire logic CHAN_EN_N,
   input wire logic SUPPLY_LEVEL_SEL,
   input wire logic SWITCH_POL_SEL,
   input wire logic CARD_SWITCH_IN,
   input wire logic HOST_RESET_IN,
   input wire logic HOST_CLOCK_IN,
   input wire logic SUPPLY_IN_REG,
   input wire logic SUPPLY_UNDER,
   input wire logic OVER_TEMP,
   input wire logic CARD_RST_SENSE,
   input wire logic CARD_CLK_SENSE,
   output logic SUPPLY_EN,
   output logic SUPPLY_LEVEL_LATCHED,
   output logic SUPPLY_DISCHARGE,
   output logic SUPPLY_READY_N,
   output logic ALARM_N,
   output logic CARD_INSERTED_N,
   output logic CARD_RST,
   output logic CARD_CLK,
   input wire logic [2:0] HOST_LINE_I,
   output logic [2:0] HOST_LINE_O,
   output logic [2:0] HOST_LINE_OE,
   input wire logic [2:0] CARD_LINE_I,
   output logic [2:0] CARD_LINE_O,
   output logic [2:0] CARD_LINE_OE
);

   generate
      if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC > 8388607) begin : g_bad_debounce
         $error("DEBOUNCE_CYC out of range");
      end
      if (UNDER_CYC < 1 || UNDER_CYC > 65535) begin : g_bad_under
         $error("UNDER_CYC out of range");
      end
   endgenerate

   scs_pkg::scs_pins_t pins_raw;
   scs_pkg::scs_pins_t meta_r;
   scs_pkg::scs_pins_t sync_r;
   scs_pkg::scs_state_t state_r;
   scs_pkg::scs_fault_t fault_r;
   scs_pkg::scs_fault_t fault_nxt;
   logic ready_r;
   logic level_r;
   logic inserted_r;
   logic [22:0] deb_cnt_r;
   logic [15:0] under_cnt_r;
   logic [15:0] rst_cnt_r;
   logic [15:0] clk_cnt_r;
   logic [15:0] cfg_mismatch_r;
   logic card_present;
   logic chan_on;
   logic checks_on;
   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] status_word;
   logic [2:0] ch_active;

   // Two-stage synchroniser on every pin input
   assign pins_raw = {POWER_REQUEST_N, CHAN_EN_N, SUPPLY_LEVEL_SEL, SWITCH_POL_SEL,
                      CARD_SWITCH_IN, HOST_RESET_IN, HOST_CLOCK_IN, SUPPLY_IN_REG,
                      SUPPLY_UNDER, OVER_TEMP, CARD_RST_SENSE, CARD_CLK_SENSE,
                      HOST_LINE_I, CARD_LINE_I};

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         meta_r <= `SCS_SYNC_RST;
         sync_r <= `SCS_SYNC_RST;
      end else begin
         meta_r <= pins_raw;
         sync_r <= meta_r;
      end
   end

   assign card_present = sync_r.switch_pol_sel ? sync_r.card_switch_in
                                               : ~sync_r.card_switch_in;
   assign checks_on = (state_r == scs_pkg::SCS_ACTIVE) && ready_r;
   assign chan_on = checks_on && !sync_r.chan_en_n;

   // Fault detection
   always_comb begin
      fault_nxt = '0;
      if (state_r == scs_pkg::SCS_ACTIVE) begin
         fault_nxt.under = (under_cnt_r >= UNDER_CYC[15:0]);
         fault_nxt.removal = !card_present;
         fault_nxt.over_temp = checks_on && sync_r.over_temp;
         fault_nxt.rst_mismatch = checks_on && (rst_cnt_r >= cfg_mismatch_r);
         fault_nxt.clk_mismatch = checks_on && (clk_cnt_r >= cfg_mismatch_r);
      end
   end

   // Underrange duration
   always_ff @(posedge CLK_SYS) begin
      if (RST || state_r != scs_pkg::SCS_ACTIVE || !sync_r.supply_under) begin
         under_cnt_r <= 16'h0000;
      end else if (under_cnt_r != 16'hFFFF) begin
         under_cnt_r <= under_cnt_r + 16'h0001;
      end
   end

   // Mismatch duration; a short skew from the pad path is tolerated
   always_ff @(posedge CLK_SYS) begin
      if (RST || !checks_on || sync_r.card_rst_sense == sync_r.host_reset_in) begin
         rst_cnt_r <= 16'h0000;
      end else if (rst_cnt_r != 16'hFFFF) begin
         rst_cnt_r <= rst_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST || !checks_on || sync_r.card_clk_sense == sync_r.host_clock_in) begin
         clk_cnt_r <= 16'h0000;
      end else if (clk_cnt_r != 16'hFFFF) begin
         clk_cnt_r <= clk_cnt_r + 16'h0001;
      end
   end

   // Main sequencer
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_r <= scs_pkg::SCS_IDLE;
      end else begin
         case (state_r)
            scs_pkg::SCS_IDLE: begin
               if (!sync_r.power_request_n) begin
                  state_r <= scs_pkg::SCS_ACTIVE;
               end
            end
            scs_pkg::SCS_ACTIVE: begin
               if (sync_r.power_request_n) begin
                  state_r <= scs_pkg::SCS_IDLE;
               end else if (fault_nxt != '0) begin
                  state_r <= scs_pkg::SCS_ALARM;
               end
            end
            scs_pkg::SCS_ALARM: begin
               if (sync_r.power_request_n) begin
                  state_r <= scs_pkg::SCS_IDLE;
               end
            end
            default: begin
               state_r <= scs_pkg::SCS_IDLE;
            end
         endcase
      end
   end

   // Causes stay visible through Alarm for software
   always_ff @(posedge CLK_SYS) begin
      if (RST || state_r == scs_pkg::SCS_IDLE) begin
         fault_r <= `SCS_FAULT_RST;
      end else if (state_r == scs_pkg::SCS_ACTIVE) begin
         fault_r <= fault_r | fault_nxt;
      end
   end

   // Level latch only on the Idle to Active step
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         level_r <= 1'b0;
      end else if (state_r == scs_pkg::SCS_IDLE && !sync_r.power_request_n) begin
         level_r <= sync_r.supply_level_sel;
      end
   end

   // Ready stays low once regulation is reached, until Active is left
   always_ff @(posedge CLK_SYS) begin
      if (RST || state_r != scs_pkg::SCS_ACTIVE || sync_r.power_request_n ||
          fault_nxt != '0) begin
         ready_r <= 1'b0;
      end else if (sync_r.supply_in_reg && fault_nxt == '0) begin
         ready_r <= 1'b1;
      end
   end

   // Card detect debounce: slow set, immediate release
   always_ff @(posedge CLK_SYS) begin
      if (RST || !card_present) begin
         deb_cnt_r <= 23'h000000;
         inserted_r <= 1'b0;
      end else if (deb_cnt_r < DEBOUNCE_CYC[22:0] - 23'h000001) begin
         deb_cnt_r <= deb_cnt_r + 23'h000001;
      end else begin
         inserted_r <= 1'b1;
      end
   end

   // Supply and card reset and clock pads
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         SUPPLY_EN <= 1'b0;
         SUPPLY_DISCHARGE <= 1'b1;
         SUPPLY_LEVEL_LATCHED <= 1'b0;
         SUPPLY_READY_N <= 1'b1;
         ALARM_N <= 1'b1;
         CARD_INSERTED_N <= 1'b1;
         CARD_RST <= 1'b0;
         CARD_CLK <= 1'b0;
      end else begin
         SUPPLY_EN <= (state_r == scs_pkg::SCS_ACTIVE);
         SUPPLY_DISCHARGE <= (state_r != scs_pkg::SCS_ACTIVE);
         SUPPLY_LEVEL_LATCHED <= level_r;
         SUPPLY_READY_N <= !ready_r;
         ALARM_N <= (state_r != scs_pkg::SCS_ALARM);
         CARD_INSERTED_N <= !inserted_r;
         CARD_RST <= checks_on && sync_r.host_reset_in;
         CARD_CLK <= checks_on && sync_r.host_clock_in;
      end
   end

   // Half-duplex direction arbiters
   generate
      for (genvar i = 0; i < 3; i++) begin : g_ch
         scs_pkg::scs_dir_t dir_r;
         logic host_hi;
         logic card_hi;

         assign host_hi = sync_r.host_line[i];
         assign card_hi = sync_r.card_line[i];
         assign ch_active[i] = (dir_r != scs_pkg::SCS_CH_REST);

         always_ff @(posedge CLK_SYS) begin
            if (RST || !chan_on) begin
               dir_r <= scs_pkg::SCS_CH_REST;
            end else begin
               case (dir_r)
                  scs_pkg::SCS_CH_REST: begin
                     // Host side wins a simultaneous low
                     if (!host_hi) begin
                        dir_r <= scs_pkg::SCS_CH_HOST_IN;
                     end else if (!card_hi) begin
                        dir_r <= scs_pkg::SCS_CH_CARD_IN;
                     end
                  end
                  scs_pkg::SCS_CH_HOST_IN: begin
                     if (host_hi) begin
                        dir_r <= scs_pkg::SCS_CH_SETTLE;
                     end
                  end
                  scs_pkg::SCS_CH_CARD_IN: begin
                     if (card_hi) begin
                        dir_r <= scs_pkg::SCS_CH_SETTLE;
                     end
                  end
                  scs_pkg::SCS_CH_SETTLE: begin
                     // Waits out our own released drive and any foreign low
                     if (host_hi && card_hi) begin
                        dir_r <= scs_pkg::SCS_CH_REST;
                     end
                  end
                  default: begin
                     dir_r <= scs_pkg::SCS_CH_REST;
                  end
               endcase
            end
         end

         always_ff @(posedge CLK_SYS) begin
            if (RST || state_r != scs_pkg::SCS_ACTIVE) begin
               CARD_LINE_O[i] <= 1'b0;
               CARD_LINE_OE[i] <= 1'b1;
               HOST_LINE_O[i] <= 1'b0;
               HOST_LINE_OE[i] <= 1'b0;
            end else if (!chan_on) begin
               CARD_LINE_O[i] <= 1'b1;
               CARD_LINE_OE[i] <= 1'b1;
               HOST_LINE_O[i] <= 1'b0;
               HOST_LINE_OE[i] <= 1'b0;
            end else begin
               CARD_LINE_O[i] <= 1'b0;
               CARD_LINE_OE[i] <= (dir_r == scs_pkg::SCS_CH_HOST_IN);
               HOST_LINE_O[i] <= 1'b0;
               HOST_LINE_OE[i] <= (dir_r == scs_pkg::SCS_CH_CARD_IN);
            end
         end
      end
   endgenerate

   // Wishbone classic slave, one wait state
   always_comb begin
      status_word = 32'h00000000;
      status_word[`SCS_ST_STATE_LO +: 2] = state_r;
      status_word[`SCS_ST_READY] = ready_r;
      status_word[`SCS_ST_INSERTED] = inserted_r;
      status_word[`SCS_ST_LEVEL] = level_r;
      status_word[`SCS_ST_CH_ON +: 3] = ch_active;
      status_word[`SCS_ST_F_UNDER] = fault_r.under;
      status_word[`SCS_ST_F_TEMP] = fault_r.over_temp;
      status_word[`SCS_ST_F_REMOVE] = fault_r.removal;
      status_word[`SCS_ST_F_RST] = fault_r.rst_mismatch;
      status_word[`SCS_ST_F_CLK] = fault_r.clk_mismatch;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= WB_CYC_I && WB_STB_I && !ack_r;
         if (WB_CYC_I && WB_STB_I && !ack_r) begin
            if (WB_ADR_I == `SCS_ADDR_STATUS) begin
               dat_r <= status_word;
            end else if (WB_ADR_I == `SCS_ADDR_CFG) begin
               dat_r <= {16'h0000, cfg_mismatch_r};
            end else begin
               dat_r <= 32'h00000000;
            end
         end
      end
   end

   // Write lands on the edge that samples ack
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cfg_mismatch_r <= `SCS_CFG_RST;
      end else if (WB_CYC_I && WB_STB_I && WB_WE_I && ack_r &&
                   WB_ADR_I == `SCS_ADDR_CFG) begin
         if (WB_SEL_I[0]) begin
            cfg_mismatch_r[7:0] <= WB_DAT_I[7:0];
         end
         if (WB_SEL_I[1]) begin
            cfg_mismatch_r[15:8] <= WB_DAT_I[15:8];
         end
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;

endmodule

// ---- verification/scs_card_model.sv ----
`timescale 1ns/1ns
module scs_card_model (
   input wire logic clk,
   input wire logic present,
   input wire logic pol,
   input wire logic [1:0] stuck,
   input wire logic card_rst,
   input wire logic card_clk,
   input wire logic [2:0] line_o,
   input wire logic [2:0] line_oe,
   input wire logic [2:0] pull_low,
   output logic switch_out,
   output logic rst_sense,
   output logic clk_sense,
   output logic [2:0] line_i
);
   logic [3:0] rst_d;
   logic [3:0] clk_d;
   assign switch_out = present ? pol : ~pol;
   // Pull-ups: released lines read high
   assign line_i = ~((line_oe & ~line_o) | pull_low);
   // Pad lag of four cycles; a shorted pad reads low
   always_ff @(posedge clk) begin
      rst_d <= {rst_d[2:0], card_rst};
      clk_d <= {clk_d[2:0], card_clk};
   end
   assign rst_sense = stuck[0] ? 1'h0 : rst_d[3];
   assign clk_sense = stuck[1] ? 1'h0 : clk_d[3];
endmodule

// ---- verification/scs_sequencer_asserts.sv ----
`timescale 1ns/1ns
module scs_seq_chk #(
   parameter int DEBOUNCE_CYC = 50,
   parameter int UNDER_CYC = 500
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic POWER_REQUEST_N,
   input wire logic CHAN_EN_N,
   input wire logic SWITCH_POL_SEL,
   input wire logic CARD_SWITCH_IN,
   input wire logic HOST_RESET_IN,
   input wire logic HOST_CLOCK_IN,
   input wire logic SUPPLY_UNDER,
   input wire logic SUPPLY_EN,
   input wire logic SUPPLY_LEVEL_LATCHED,
   input wire logic SUPPLY_DISCHARGE,
   input wire logic SUPPLY_READY_N,
   input wire logic ALARM_N,
   input wire logic CARD_INSERTED_N,
   input wire logic CARD_RST,
   input wire logic CARD_CLK,
   input wire logic [2:0] HOST_LINE_OE,
   input wire logic [2:0] CARD_LINE_OE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   int under_r;
   int card_switch_in_r;
   // Raw pins lead the design's synchronised copies, hence the margins
   always_ff @(posedge CLK_SYS) begin
      if (RST || !SUPPLY_UNDER || !SUPPLY_EN) begin
         under_r <= 0;
      end else begin
         under_r <= under_r + 1;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RST || CARD_SWITCH_IN != SWITCH_POL_SEL) begin
         card_switch_in_r <= 0;
      end else if (card_switch_in_r < DEBOUNCE_CYC + 99) begin
         card_switch_in_r <= card_switch_in_r + 1;
      end
   end
   sequence s_req_fall;
      $fell(POWER_REQUEST_N) ##1 (!POWER_REQUEST_N) [*5];
   endsequence
   sequence s_held_low;
      (!POWER_REQUEST_N) [*4];
   endsequence
   property p_supply_on;
      s_req_fall |-> SUPPLY_EN || !ALARM_N;
   endproperty
   a_supply_on: assert property (p_supply_on)
      else $error("supply not enabled after request");
   property p_gated;
      SUPPLY_READY_N && $past(SUPPLY_READY_N) |-> !CARD_RST && !CARD_CLK
         && HOST_LINE_OE == 3'h0 && CARD_LINE_OE == 3'h7;
   endproperty
   a_gated: assert property (p_gated)
      else $error("channels active without supply ready");
   property p_chan_off;
      CHAN_EN_N [*6] |-> HOST_LINE_OE == 3'h0 && CARD_LINE_OE == 3'h7;
   endproperty
   a_chan_off: assert property (p_chan_off)
      else $error("disabled channels not parked");
   property p_level;
      (!POWER_REQUEST_N) [*8] |=> $stable(SUPPLY_LEVEL_LATCHED);
   endproperty
   a_level: assert property (p_level)
      else $error("latched level moved during request");
   property p_alarm_hold;
      s_held_low ##0 !ALARM_N |=> !ALARM_N;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold)
      else $error("alarm cleared while request low");
   property p_idle;
      POWER_REQUEST_N [*6] |-> ALARM_N && !SUPPLY_EN && SUPPLY_DISCHARGE && SUPPLY_READY_N;
   endproperty
   a_idle: assert property (p_idle)
      else $error("not idle after request release");
   property p_follow;
      (!SUPPLY_READY_N && $stable(HOST_RESET_IN)) [*5] |-> CARD_RST == HOST_RESET_IN;
   endproperty
   a_follow: assert property (p_follow)
      else $error("card reset not following host");
   property p_clk_follow;
      (!SUPPLY_READY_N && $stable(HOST_CLOCK_IN)) [*5] |-> CARD_CLK == HOST_CLOCK_IN;
   endproperty
   a_clk_follow: assert property (p_clk_follow)
      else $error("card clock not following host");
   property p_under;
      under_r < UNDER_CYC + 10;
   endproperty
   a_under: assert property (p_under)
      else $error("underrange did not raise alarm");
   property p_ins_late;
      card_switch_in_r == DEBOUNCE_CYC + 6 |-> !CARD_INSERTED_N;
   endproperty
   a_ins_late: assert property (p_ins_late)
      else $error("inserted flag late");
   property p_ins_early;
      $fell(CARD_INSERTED_N) |-> card_switch_in_r >= DEBOUNCE_CYC;
   endproperty
   a_ins_early: assert property (p_ins_early)
      else $error("inserted flag early");
   property p_release;
      (CARD_SWITCH_IN != SWITCH_POL_SEL) [*6] |-> CARD_INSERTED_N;
   endproperty
   a_release: assert property (p_release)
      else $error("inserted flag held without card");
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   localparam int DEB = 50;
   localparam int MISM = 128;
   logic CLK_SYS, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
   logic [7:0] WB_ADR_I;
   logic [3:0] WB_SEL_I;
   logic [31:0] WB_DAT_I, WB_DAT_O;
   logic POWER_REQUEST_N, CHAN_EN_N, SUPPLY_LEVEL_SEL, SWITCH_POL_SEL, CARD_SWITCH_IN;
   logic HOST_RESET_IN, HOST_CLOCK_IN, SUPPLY_IN_REG, SUPPLY_UNDER, OVER_TEMP;
   logic CARD_RST_SENSE, CARD_CLK_SENSE, SUPPLY_EN, SUPPLY_LEVEL_LATCHED, SUPPLY_DISCHARGE;
   logic SUPPLY_READY_N, ALARM_N, CARD_INSERTED_N, CARD_RST, CARD_CLK, present, clk_run;
   logic [2:0] HOST_LINE_I, HOST_LINE_O, HOST_LINE_OE, CARD_LINE_I, CARD_LINE_O, CARD_LINE_OE;
   logic [2:0] host_low, card_low;
   logic [1:0] stuck;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   scs_sequencer #(.DEBOUNCE_CYC(DEB)) DUT (.*);
   scs_card_model u_card (.clk(CLK_SYS), .present(present), .pol(SWITCH_POL_SEL),
      .stuck(stuck), .card_rst(CARD_RST), .card_clk(CARD_CLK), .line_o(CARD_LINE_O),
      .line_oe(CARD_LINE_OE), .pull_low(card_low), .switch_out(CARD_SWITCH_IN),
      .rst_sense(CARD_RST_SENSE), .clk_sense(CARD_CLK_SENSE), .line_i(CARD_LINE_I));
   assign HOST_LINE_I = ~((HOST_LINE_OE & ~HOST_LINE_O) | host_low);
   initial begin
      CLK_SYS = 1'h0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   // Host clock parks high when stopped, as in clock stop mode
   initial begin
      HOST_CLOCK_IN = 1'h0;
      forever begin
         #62 HOST_CLOCK_IN <= clk_run ? ~HOST_CLOCK_IN : 1'h1;
         #63 HOST_CLOCK_IN <= clk_run ? ~HOST_CLOCK_IN : 1'h1;
      end
   end
   task automatic close_out();
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge CLK_SYS) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 60000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic clks(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   task automatic wait_lo(ref logic sig, input int lim);
      for (int i = 0; i < lim && sig !== 1'h0; i++) @(posedge CLK_SYS);
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge CLK_SYS);
      WB_CYC_I <= 1'h1;
      WB_STB_I <= 1'h1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      do begin
         @(posedge CLK_SYS);
      end while (WB_ACK_O !== 1'h1);
      q = WB_DAT_O;
      WB_CYC_I <= 1'h0;
      WB_STB_I <= 1'h0;
   endtask
   // Supply off: discharge on, card pins low, host lines released
   task automatic chk_off(input string nm, input logic al_n);
      chk(nm, {ALARM_N, SUPPLY_EN, SUPPLY_DISCHARGE, SUPPLY_READY_N, CARD_RST, CARD_CLK,
         CARD_LINE_OE, CARD_LINE_O, HOST_LINE_OE}, {al_n, 14'h19C0});
   endtask
   task automatic t_regs();
      logic [31:0] q;
      wb(1'h0, 8'h04, 32'h0, q);
      chk("cfg reset", q, 32'h0000012C);
      wb(1'h1, 8'h04, MISM, q);
      wb(1'h0, 8'h04, 32'h0, q);
      chk("cfg", q, MISM);
      wb(1'h1, 8'h40, 32'hFFFFFFFF, q);
      wb(1'h0, 8'h40, 32'h0, q);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_insert();
      for (int p = 0; p < 2; p++) begin
         SWITCH_POL_SEL <= p[0];
         present <= 1'h0;
         clks(8);
         chk("no card", CARD_INSERTED_N, 1'h1);
         present <= 1'h1;
         clks(DEB - 5);
         chk("early", CARD_INSERTED_N, 1'h1);
         clks(12);
         chk("card", CARD_INSERTED_N, 1'h0);
      end
   endtask
   task automatic power_up(input logic lvl);
      SUPPLY_LEVEL_SEL <= lvl;
      POWER_REQUEST_N <= 1'h0;
      clks(6);
      chk("on", {SUPPLY_EN, SUPPLY_DISCHARGE, SUPPLY_LEVEL_LATCHED}, {2'h2, lvl});
      SUPPLY_LEVEL_SEL <= ~lvl;
      clks(MISM + 20);
      chk("unready", {ALARM_N, CARD_RST, CARD_LINE_O, CARD_LINE_OE, HOST_LINE_OE},
         11'h5F8);
      SUPPLY_IN_REG <= 1'h1;
      wait_lo(SUPPLY_READY_N, 10);
      clks(6);
      chk("ready", {SUPPLY_READY_N, CARD_RST, SUPPLY_LEVEL_LATCHED}, {2'h1, lvl});
      HOST_RESET_IN <= 1'h0;
      clks(6);
      chk("rst follow", CARD_RST, 1'h0);
      HOST_RESET_IN <= 1'h1;
      clks(6);
      chk("rest", {CARD_RST, CARD_LINE_I, HOST_LINE_I}, 7'h7F);
   endtask
   task automatic power_down();
      POWER_REQUEST_N <= 1'h1;
      SUPPLY_IN_REG <= 1'h0;
      clks(6);
      chk_off("idle", 1'h1);
   endtask
   task automatic t_chan();
      logic [2:0] m;
      power_up(1'h1);
      for (int c = 0; c < 3; c++) begin
         m = 3'h1 << c;
         host_low <= m;
         clks(6);
         chk("to card", {CARD_LINE_I & m, HOST_LINE_OE}, 6'h0);
         card_low <= m;
         clks(6);
         chk("no back", HOST_LINE_OE, 3'h0);
         host_low <= 3'h0;
         clks(6);
         chk("late low", HOST_LINE_I, 3'h7);
         card_low <= 3'h0;
         clks(6);
         chk("rest", {CARD_LINE_I, HOST_LINE_I}, 6'h3F);
         card_low <= m;
         clks(6);
         chk("to host", HOST_LINE_I, m ^ 3'h7);
         card_low <= 3'h0;
         clks(6);
      end
      CHAN_EN_N <= 1'h1;
      host_low <= 3'h7;
      clks(6);
      chk("off", {CARD_LINE_I, CARD_LINE_OE, HOST_LINE_OE}, 9'h1F8);
      chk("supply", {SUPPLY_EN, SUPPLY_READY_N, CARD_RST}, 3'h5);
      host_low <= 3'h0;
      CHAN_EN_N <= 1'h0;
      power_down();
   endtask
   task automatic t_faults();
      logic [31:0] q;
      int early;
      for (int k = 0; k < 5; k++) begin
         power_up(k[0]);
         early = (k == 0) ? 490 : (k > 2 ? MISM - 10 : 0);
         case (k)
            0: SUPPLY_UNDER <= 1'h1;
            1: OVER_TEMP <= 1'h1;
            2: present <= 1'h0;
            3: stuck <= 2'h1;
            default: begin
               clk_run <= 1'h0;
               stuck <= 2'h2;
            end
         endcase
         if (early > 0) begin
            clks(early);
            chk("no alarm yet", ALARM_N, 1'h1);
         end
         wait_lo(ALARM_N, 40);
         chk("alarm", ALARM_N, 1'h0);
         {SUPPLY_UNDER, OVER_TEMP, present, stuck, clk_run} <= 6'h09;
         clks(20);
         chk_off("held", 1'h0);
         wb(1'h0, 8'h00, 32'h0, q);
         chk("status", {q[1:0], q[8 + k]}, 3'h5);
         power_down();
      end
   endtask
   initial begin
      {RST, WB_CYC_I, WB_STB_I, WB_WE_I, POWER_REQUEST_N, CHAN_EN_N} = 6'h23;
      {SUPPLY_LEVEL_SEL, SWITCH_POL_SEL, HOST_RESET_IN, SUPPLY_IN_REG} = 4'h2;
      {SUPPLY_UNDER, OVER_TEMP, present, stuck, clk_run} = 6'h01;
      {host_low, card_low} = 6'h0;
      WB_ADR_I = 8'h00;
      WB_SEL_I = 4'hF;
      WB_DAT_I = 32'h0;
      clks(8);
      RST <= 1'h0;
      clks(1);
      chk_off("reset", 1'h1);
      CHAN_EN_N <= 1'h0;
      t_regs();
      t_insert();
      t_chan();
      t_faults();
      close_out();
   end
endmodule
bind scs_sequencer scs_seq_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .UNDER_CYC(UNDER_CYC)) u_chk (.*);
